// ---- gpio_boot_strap_port.sv ----
// sixteen-pin gpio port with boot strap capture and event routing
// Summary of operation
// - every strap pin level is latched into the configuration state on the third clock after power-on reset releases.
// - after the straps are latched the pins become ordinary general purpose I/O.
// - the port takes register writes and raises events only after strap capture, and every pin direction defaults to input.
// - each pin can raise a dma event and an interrupt, the interrupt routable to any processor core.
// - pin 0 is endianness (high little), 1-3 boot device, 4-10 device config, 11-13 pll or i2c, 14-15 pcie role.
// - after boot each pin is released and rests in its default idle state unless software changes it.
// - unconnected pin 0 pulls high and pins 1 to 15 pull low, setting their strap values.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module gpio_boot_strap_port #(
    parameter int unsigned PIN_CNT = 16
) (
    // clock and reset
    input  wire logic                                core_clk_i,
    input  wire logic                                rst_n_i,
    // avalon-mm slave
    input  wire logic [gpio_strap_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                                avs_read_i,
    input  wire logic                                avs_write_i,
    input  wire logic [31:0]                         avs_writedata_i,
    input  wire logic [3:0]                          avs_byteenable_i,
    output logic      [31:0]                         avs_readdata_o,
    output logic                                     avs_waitrequest_o,
    // pins
    input  wire logic [PIN_CNT-1:0]                  pin_in_i,
    output logic      [PIN_CNT-1:0]                  pin_out_o,
    output logic      [PIN_CNT-1:0]                  pin_oe_o,
    output logic      [PIN_CNT-1:0]                  pin_pull_up_o,
    output logic      [PIN_CNT-1:0]                  pin_pull_dn_o,
    // strap results and status
    output gpio_strap_pkg::strap_cfg_t               strap_cfg_o,
    output logic                                     reset_status_out_n_o,
    // events
    output logic                                     irq_o,
    output logic      [gpio_strap_pkg::NUM_CORES-1:0] core_irq_o,
    output logic      [PIN_CNT-1:0]                  dma_evt_o
);
    import gpio_strap_pkg::*;

    // ==========================================================
    // state
    logic [PIN_CNT-1:0] pins_s;
    logic [PIN_CNT-1:0] evt_w;
    logic [1:0]         settle_q;
    logic               captured_q;
    logic [PIN_CNT-1:0] strap_raw_q;
    logic [PIN_CNT-1:0] dir_q;
    logic [PIN_CNT-1:0] out_q;
    logic [PIN_CNT-1:0] rise_en_q;
    logic [PIN_CNT-1:0] fall_en_q;
    logic [PIN_CNT-1:0] stat_q;
    logic [PIN_CNT-1:0] mask_q;
    logic [31:0]        route_q;
    logic [PIN_CNT-1:0] pull_up_q;
    logic [PIN_CNT-1:0] pull_dn_q;
    logic               ack_q;
    logic               wait_q;
    logic [31:0]        rdata_q;

    // ==========================================================
    // pin synchroniser, reset to the pull defaults
    // pull default levels
    pin_sync #(
        .W       (PIN_CNT),
        .RST_VAL (PULL_UP_RST)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    (pin_in_i),
        .sync_o     (pins_s)
    );

    // ==========================================================
    // strap capture after reset release
    wire capture_w = !captured_q && (settle_q == STRAP_SETTLE);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_q    <= '0;
            captured_q  <= 1'b0;
            strap_raw_q <= '0;
        end else begin
            if (!captured_q && settle_q != STRAP_SETTLE) begin
                settle_q <= settle_q + 2'h1;
            end
            if (capture_w) begin
                strap_raw_q <= pins_s;
                captured_q  <= 1'b1;
            end
        end
    end

    assign strap_cfg_o = strap_cfg_t'(strap_raw_q);
    assign reset_status_out_n_o = captured_q;

    // ==========================================================
    // bus decode
    wire req_w   = (avs_read_i || avs_write_i) && !ack_q;
    wire wr_w    = avs_write_i && ack_q;
    wire [31:0] be_mask_w = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wire [31:0] wd_w = avs_writedata_i & be_mask_w;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [31:0] bm);
        merge16 = (old & ~bm[15:0]) | wd[15:0];
    endfunction

    wire sel_dir   = wr_w && (avs_address_i == OFS_DIR);
    wire sel_out   = wr_w && (avs_address_i == OFS_OUT);
    wire sel_rise  = wr_w && (avs_address_i == OFS_RISE_EN);
    wire sel_fall  = wr_w && (avs_address_i == OFS_FALL_EN);
    wire sel_stat  = wr_w && (avs_address_i == OFS_STAT);
    wire sel_mask  = wr_w && (avs_address_i == OFS_MASK);
    wire sel_route = wr_w && (avs_address_i == OFS_ROUTE);
    wire sel_pu    = wr_w && (avs_address_i == OFS_PULL_UP);
    wire sel_pd    = wr_w && (avs_address_i == OFS_PULL_DN);

    logic [31:0] rmux_w;
    always_comb begin
        if (avs_address_i == OFS_DIR) begin
            rmux_w = {16'h0000, dir_q};
        end else if (avs_address_i == OFS_OUT) begin
            rmux_w = {16'h0000, out_q};
        end else if (avs_address_i == OFS_IN) begin
            rmux_w = {16'h0000, pins_s};
        end else if (avs_address_i == OFS_RISE_EN) begin
            rmux_w = {16'h0000, rise_en_q};
        end else if (avs_address_i == OFS_FALL_EN) begin
            rmux_w = {16'h0000, fall_en_q};
        end else if (avs_address_i == OFS_STAT) begin
            rmux_w = {16'h0000, stat_q};
        end else if (avs_address_i == OFS_MASK) begin
            rmux_w = {16'h0000, mask_q};
        end else if (avs_address_i == OFS_ROUTE) begin
            rmux_w = route_q;
        end else if (avs_address_i == OFS_PULL_UP) begin
            rmux_w = {16'h0000, pull_up_q};
        end else if (avs_address_i == OFS_PULL_DN) begin
            rmux_w = {16'h0000, pull_dn_q};
        end else if (avs_address_i == OFS_STRAP) begin
            rmux_w = {16'h0000, strap_raw_q};
        end else begin
            rmux_w = 32'h0000_0000;
        end
    end

    // ==========================================================
    // bus handshake: one wait cycle per access
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q   <= 1'b0;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req_w;
            wait_q <= !req_w;
            if (req_w && avs_read_i) begin
                rdata_q <= rmux_w;
            end
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata_q;

    // ==========================================================
    // control registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_q     <= DIR_RST;
            out_q     <= '0;
            rise_en_q <= '0;
            fall_en_q <= '0;
            mask_q    <= '0;
            route_q   <= ROUTE_RST;
            pull_up_q <= PULL_UP_RST;
            pull_dn_q <= PULL_DN_RST;
        end else if (captured_q) begin
            // software may leave the idle state
            if (sel_dir)   dir_q     <= merge16(dir_q, wd_w, be_mask_w);
            if (sel_out)   out_q     <= merge16(out_q, wd_w, be_mask_w);
            if (sel_rise)  rise_en_q <= merge16(rise_en_q, wd_w, be_mask_w);
            if (sel_fall)  fall_en_q <= merge16(fall_en_q, wd_w, be_mask_w);
            if (sel_mask)  mask_q    <= merge16(mask_q, wd_w, be_mask_w);
            if (sel_route) route_q   <= (route_q & ~be_mask_w) | wd_w;
            if (sel_pu)    pull_up_q <= merge16(pull_up_q, wd_w, be_mask_w);
            if (sel_pd)    pull_dn_q <= merge16(pull_dn_q, wd_w, be_mask_w);
        end
    end

    // ==========================================================
    // pin drivers
    // pins handed to gpio after capture
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_out_o     <= '0;
            pin_oe_o      <= '0;
            pin_pull_up_o <= PULL_UP_RST;
            pin_pull_dn_o <= PULL_DN_RST;
        end else begin
            pin_out_o     <= out_q;
            pin_oe_o      <= captured_q ? dir_q : '0;
            pin_pull_up_o <= pull_up_q;
            pin_pull_dn_o <= pull_dn_q;
        end
    end

    // ==========================================================
    // events
    pin_edge_detect #(
        .W (PIN_CNT)
    ) u_edge (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (captured_q),
        .rise_en_i  (rise_en_q),
        .fall_en_i  (fall_en_q),
        .pin_i      (pins_s),
        .event_o    (evt_w)
    );

    wire [PIN_CNT-1:0] pend_w = stat_q & mask_q;
    wire               irq_any_w = |pend_w;

    function automatic logic core_hit(input logic [PIN_CNT-1:0] pend,
                                      input logic [31:0] route,
                                      input int unsigned core);
        logic hit;
        hit = 1'b0;
        for (int unsigned i = 0; i < PIN_CNT; i++) begin
            if (pend[i] && route[2*i +: CORE_SEL_W] == CORE_SEL_W'(core)) begin
                hit = 1'b1;
            end
        end
        core_hit = hit;
    endfunction

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q     <= '0;
            irq_o      <= 1'b0;
            core_irq_o <= '0;
            dma_evt_o  <= '0;
        end else begin
            stat_q    <= (sel_stat ? (stat_q & ~wd_w[15:0]) : stat_q) | evt_w;
            irq_o     <= irq_any_w;
            dma_evt_o <= evt_w;
            for (int unsigned c = 0; c < NUM_CORES; c++) begin
                core_irq_o[c] <= core_hit(pend_w, route_q, c);
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_strap_latch: assert property ($rose(captured_q) |-> strap_raw_q == $past(pins_s))
        else $error("straps not latched from synchronised pins");
    chk_capture_time: assert property (rst_n_i && !captured_q |-> ##[1:3] captured_q)
        else $error("strap capture late");
    chk_pins_released: assert property (!captured_q |=> pin_oe_o == '0)
        else $error("pin driven during strap phase");
    chk_dir_default: assert property (!captured_q |-> dir_q == DIR_RST)
        else $error("direction not input at power-up");
    chk_event_sets: assert property (|evt_w |=> (stat_q & $past(evt_w)) == $past(evt_w))
        else $error("event lost in status");
    chk_irq_level: assert property (irq_any_w |=> irq_o)
        else $error("interrupt not raised");
    chk_dma_pulse: assert property (##1 dma_evt_o == $past(evt_w))
        else $error("dma event mismatch");
    chk_strap_fields: assert property (captured_q |-> strap_cfg_o.endian_select_strap
                                       == strap_raw_q[0] && strap_cfg_o.pcie_role
                                       == strap_raw_q[15:14])
        else $error("strap decode wrong");
    chk_idle_release: assert property ($rose(captured_q) |-> dir_q == DIR_RST
                                       && pull_up_q == PULL_UP_RST)
        else $error("pins not idle after boot");
    chk_pull_default: assert property (!captured_q |-> pin_pull_up_o == PULL_UP_RST
                                       && pin_pull_dn_o == PULL_DN_RST)
        else $error("pull defaults wrong during boot");
    chk_strap_hold: assert property (captured_q |=> $stable(strap_raw_q))
        else $error("straps changed after capture");
    chk_bus_ack: assert property (req_w |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer timing wrong");

    cov_capture: cover property ($rose(captured_q));
    cov_event_irq: cover property (|evt_w ##2 irq_o);
    cov_stat_clear: cover property (sel_stat && |stat_q);
    cov_pin_drive: cover property (|pin_oe_o);

endmodule
`default_nettype wire

// ---- gpio_strap_pkg.sv ----
// constants and types for the strap-capable gpio port
package gpio_strap_pkg;

    // ==========================================================
    // geometry
    localparam int unsigned PIN_W      = 16;
    localparam int unsigned NUM_CORES  = 4;
    localparam int unsigned CORE_SEL_W = 2;
    localparam int unsigned ADDR_W     = 6;

    // ==========================================================
    // register byte offsets
    localparam logic [5:0] OFS_DIR      = 6'h00;
    localparam logic [5:0] OFS_OUT      = 6'h04;
    localparam logic [5:0] OFS_IN       = 6'h08;
    localparam logic [5:0] OFS_RISE_EN  = 6'h0c;
    localparam logic [5:0] OFS_FALL_EN  = 6'h10;
    localparam logic [5:0] OFS_STAT     = 6'h14;
    localparam logic [5:0] OFS_MASK     = 6'h18;
    localparam logic [5:0] OFS_ROUTE    = 6'h1c;
    localparam logic [5:0] OFS_PULL_UP  = 6'h20;
    localparam logic [5:0] OFS_PULL_DN  = 6'h24;
    localparam logic [5:0] OFS_STRAP    = 6'h28;

    // ==========================================================
    // reset values
    localparam logic [15:0] DIR_RST     = 16'h0000;
    localparam logic [15:0] PULL_UP_RST = 16'h0001;
    localparam logic [15:0] PULL_DN_RST = 16'hfffe;
    localparam logic [31:0] ROUTE_RST   = 32'h0000_0000;

    // ==========================================================
    // timing: synchroniser depth before straps are valid
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // ==========================================================
    // strap field layout, msb first: pin 15 .. pin 0
    typedef struct packed {
        logic [1:0] pcie_role;
        logic [2:0] pll_i2c_sel;
        logic [6:0] dev_cfg;
        logic [2:0] boot_dev;
        logic       endian_select_strap;
    } strap_cfg_t;

endpackage

// ---- pin_sync.sv ----
// two-flop synchroniser for a vector of pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int unsigned      W       = 16,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    // pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- pin_edge_detect.sv ----
// per-pin rising and falling edge event detector
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect #(
    parameter int unsigned W = 16
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    // control
    input  wire logic         enable_i,
    input  wire logic [W-1:0] rise_en_i,
    input  wire logic [W-1:0] fall_en_i,
    // pins and events
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] event_o
);
    logic [W-1:0] prev_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= pin_i;
        end
    end

    assign event_o = enable_i ? ((pin_i & ~prev_q & rise_en_i)
                              | (~pin_i & prev_q & fall_en_i)) : '0;
endmodule
`default_nettype wire

// ---- board_strap_model.sv ----
// board side: strap drivers, gpio drivers and pad level resolution
`timescale 1ns/1ns
`default_nettype none
module board_strap_model (
    // clock
    input  wire logic                               core_clk_i,
    // board control
    input  wire logic                               reset_status_out_n_i,
    input  wire logic                               strap_en_i,
    input  wire logic [gpio_strap_pkg::PIN_W-1:0]   strap_val_i,
    input  wire logic [gpio_strap_pkg::PIN_W-1:0]   gpio_en_i,
    input  wire logic [gpio_strap_pkg::PIN_W-1:0]   gpio_val_i,
    // device pad side
    input  wire logic [gpio_strap_pkg::PIN_W-1:0]   pin_oe_i,
    input  wire logic [gpio_strap_pkg::PIN_W-1:0]   pin_out_i,
    input  wire logic [gpio_strap_pkg::PIN_W-1:0]   pin_pull_up_i,
    input  wire logic [gpio_strap_pkg::PIN_W-1:0]   pin_pull_dn_i,
    output logic      [gpio_strap_pkg::PIN_W-1:0]   pin_lvl_o
);
    import gpio_strap_pkg::*;
    logic [PIN_W-1:0] last_q;
    // ==========================================================
    // pad resolution
    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            if (pin_oe_i[i]) begin
                pin_lvl_o[i] = pin_out_i[i];
            // straps held until reset status, then tri-stated
            end else if (!reset_status_out_n_i && strap_en_i) begin
                pin_lvl_o[i] = strap_val_i[i];
            end else if (gpio_en_i[i]) begin
                pin_lvl_o[i] = gpio_val_i[i];
            end else if (pin_pull_up_i[i]) begin
                pin_lvl_o[i] = 1'b1;
            end else if (pin_pull_dn_i[i]) begin
                pin_lvl_o[i] = 1'b0;
            end else begin
                pin_lvl_o[i] = ~last_q[i];
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        last_q <= pin_lvl_o;
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the strap-capable gpio port
`timescale 1ns/1ns
`default_nettype none
module tb;
    import gpio_strap_pkg::*;
    logic core_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
    logic reset_status_out_n_o, strap_en;
    logic [5:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic [15:0] pin_lvl, pin_out_o, pin_oe_o, pull_up, pull_dn, dma_evt_o;
    logic [15:0] strap_val, gpio_en, gpio_val, v, d, o;
    logic [3:0] core_irq_o;
    strap_cfg_t strap_cfg_o;
    int err_total, checks_done, dma_cnt, n0, p;
    gpio_boot_strap_port #(.PIN_CNT(16)) gpio_boot_strap_port_i (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .pin_in_i(pin_lvl), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
        .pin_pull_up_o(pull_up), .pin_pull_dn_o(pull_dn), .strap_cfg_o(strap_cfg_o),
        .reset_status_out_n_o(reset_status_out_n_o), .irq_o(irq_o),
        .core_irq_o(core_irq_o), .dma_evt_o(dma_evt_o));
    board_strap_model board_strap_model_i (
        .core_clk_i(core_clk_i), .reset_status_out_n_i(reset_status_out_n_o),
        .strap_en_i(strap_en), .strap_val_i(strap_val), .gpio_en_i(gpio_en),
        .gpio_val_i(gpio_val), .pin_oe_i(pin_oe_o), .pin_out_i(pin_out_o),
        .pin_pull_up_i(pull_up), .pin_pull_dn_i(pull_dn), .pin_lvl_o(pin_lvl));
    // ==========================================================
    // clock and event counter
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) dma_cnt <= dma_cnt + $countones(dma_evt_o);
    // ==========================================================
    // expectations
    function automatic logic [15:0] exp_in(logic [15:0] dr, logic [15:0] ou, logic [15:0] gv);
        return (ou & dr) | (gv & ~dr);
    endfunction
    function automatic logic [31:0] exp_route(int pin, int core);
        return 32'(core) << (2 * pin);
    endfunction
    // ==========================================================
    // report and compare
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        err_total++;
        $display("unexpected at %0t: %s timed out", $time, what);
        end_of_test();
    endtask
    // ==========================================================
    // avalon-mm master
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 50) hang("bus");
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, a, wd, q);
    endtask
    task automatic do_reset(input logic en, input logic [15:0] sv);
        int n;
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        strap_en <= en;
        strap_val <= sv;
        gpio_en <= 16'h0000;
        repeat (16) @(posedge core_clk_i);
        chk(reset_status_out_n_o, 1'b0, "status in reset");
        rst_n_i <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (reset_status_out_n_o !== 1'b1 && n < 10);
        if (n >= 10) hang("capture");
        repeat (2) @(posedge core_clk_i);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 6'h00;
        avs_writedata_i = 32'h0000_0000;
        strap_en = 1'b0;
        strap_val = 16'h0000;
        gpio_en = 16'h0000;
        gpio_val = 16'h0000;
        err_total = 0;
        checks_done = 0;
        dma_cnt = 0;
        void'($urandom(32'h1f1f));
        // unconnected straps and defaults
        do_reset(1'b0, 16'h0000);
        chk(strap_cfg_o, 32'h0000_0001, "open straps");
        chk(pull_up, PULL_UP_RST, "pull up");
        chk(pull_dn, PULL_DN_RST, "pull dn");
        chk(pin_oe_o, 16'h0000, "oe default");
        bus(1'b0, OFS_DIR, 0, rd);
        chk(rd, DIR_RST, "dir reset");
        bus(1'b0, OFS_IN, 0, rd);
        chk(rd, 32'h0000_0001, "idle levels");
        bus(1'b0, 6'h3c, 0, rd);
        chk(rd, 32'h0000_0000, "unmapped");
        // driven straps, incl. boundary patterns
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 16'hffff : ((k == 1) ? 16'h0000 : 16'($urandom));
            do_reset(1'b1, v);
            chk(strap_cfg_o, v, "strap capture");
            chk(strap_cfg_o.endian_select_strap, v[0], "endian");
            chk(strap_cfg_o.boot_dev, v[3:1], "boot dev");
            chk(strap_cfg_o.dev_cfg, v[10:4], "dev cfg");
            chk(strap_cfg_o.pll_i2c_sel, v[13:11], "pll sel");
            chk(strap_cfg_o.pcie_role, v[15:14], "pcie role");
            bus(1'b0, OFS_STRAP, 0, rd);
            chk(rd, {16'h0000, v}, "strap reg");
            @(posedge core_clk_i);
            gpio_en <= 16'hffff;
            gpio_val <= ~v;
            repeat (4) @(posedge core_clk_i);
            chk(strap_cfg_o, v, "strap hold");
            bus(1'b0, OFS_IN, 0, rd);
            chk(rd, {16'h0000, ~v}, "pins as gpio");
            d = 16'($urandom);
            o = 16'($urandom);
            wr(OFS_DIR, {16'h0000, d});
            wr(OFS_OUT, {16'h0000, o});
            repeat (4) @(posedge core_clk_i);
            chk(pin_oe_o, d, "dir out");
            chk(pin_out_o, o, "out data");
            bus(1'b0, OFS_IN, 0, rd);
            chk(rd, exp_in(d, o, ~v), "in mix");
            chk(strap_cfg_o, v, "strap after io");
        end
        // events routed to every core
        wr(OFS_DIR, 0);
        for (int c = 0; c < NUM_CORES; c++) begin
            p = $urandom_range(15, 0);
            @(posedge core_clk_i);
            gpio_val <= 16'h0000;
            repeat (6) @(posedge core_clk_i);
            wr(OFS_RISE_EN, 32'h1 << p);
            wr(OFS_FALL_EN, 32'h1 << p);
            wr(OFS_STAT, 32'h0000_ffff);
            wr(OFS_MASK, 32'h1 << p);
            wr(OFS_ROUTE, exp_route(p, c));
            n0 = dma_cnt;
            gpio_val[p] <= 1'b1;
            repeat (8) @(posedge core_clk_i);
            chk(dma_cnt - n0, 1, "dma pulse");
            chk(irq_o, 1'b1, "irq");
            chk(core_irq_o, 4'h1 << c, "core route");
            bus(1'b0, OFS_STAT, 0, rd);
            chk(rd, 32'h1 << p, "stat");
            wr(OFS_STAT, 32'h1 << p);
            repeat (3) @(posedge core_clk_i);
            chk(irq_o, 1'b0, "irq cleared");
            wr(OFS_MASK, 0);
            gpio_val[p] <= 1'b0;
            repeat (8) @(posedge core_clk_i);
            bus(1'b0, OFS_STAT, 0, rd);
            chk(rd, 32'h1 << p, "fall stat");
            chk(irq_o, 1'b0, "masked");
            wr(OFS_STAT, 32'h1 << p);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
